// *** design/irf_regs.svh ***
/*
 * Register map, field positions and reset values of the request flag block.
 * Assumes inclusion by the package and the top module only.
 */
`ifndef IRF_REGS_SVH
`define IRF_REGS_SVH

// ==========================================================
// Register offsets (word index on the plain register port)
`define IRF_ADDR_W        4
`define IRF_OFS_FLAGS_ONE 4'h0
`define IRF_OFS_FLAGS_TWO 4'h1
`define IRF_OFS_ENABLE    4'h2
`define IRF_OFS_IRQ_STAT  4'h3
`define IRF_OFS_IRQ_MASK  4'h4

// ==========================================================
// Field positions, register one
`define IRF_B1_TIMER_A    7
`define IRF_B1_RSVD_RW    6
`define IRF_B1_RSVD_ONE   5
// Field positions, register two
`define IRF_B2_DIRECT     7
`define IRF_B2_ADC        6
`define IRF_B2_RSVD_RW    5
`define IRF_B2_TIMER_G    4
`define IRF_B2_TF_HIGH    3
`define IRF_B2_TF_LOW     2
`define IRF_B2_TIMER_C    1
`define IRF_B2_EVCNT      0
// Enable register
`define IRF_B_EVCNT_EN    0

// ==========================================================
// Reset values and masks
`define IRF_RST_ONE       8'h20
`define IRF_RST_ZERO      8'h00
`define IRF_FLAG_MASK_ONE 8'h9f
`define IRF_FLAG_MASK_TWO 8'hdf
`define IRF_STAT_W        2

`endif

// *** design/irf_pkg.sv ***
/*
 * Types of the request flag block.
 * Assumes irf_regs.svh is on the include path.
 */
`include "irf_regs.svh"

package irf_pkg;

  // ==========================================================
  // Source events, one-cycle pulses from peripherals
  typedef struct packed {
    logic       timer_a_wrap;
    logic [4:0] ext_edge;
    logic       direct_xfer;
    logic       adc_done;
    logic       timer_g;
    logic       tf_high;
    logic       tf_low;
    logic       timer_c;
    logic       evcnt;
  } irf_events_t;

  // Register port request
  typedef struct packed {
    logic [`IRF_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
    logic                   wr;
    logic                   rd;
  } irf_bus_t;

  // Whole state of the block
  typedef struct packed {
    logic [7:0]             flags_one;
    logic [7:0]             flags_two;
    logic                   evcnt_en;
    logic [`IRF_STAT_W-1:0] irq_stat;
    logic [`IRF_STAT_W-1:0] irq_mask;
    logic [7:0]             rdata;
    logic                   irq;
    logic [7:0]             req_one;
    logic [7:0]             req_two;
  } irf_state_t;

endpackage

// *** design/irf_top.sv ***
/*
 * Interrupt request flags: two flag registers set by peripheral events,
 * cleared by software writing 0, plus event counter enable and a summary
 * interrupt. Assumes event inputs are one-cycle pulses on clk, already
 * qualified by their peripheral (edge select, pin mode, mode of timer).
 */
// Implementation choices: the register offsets and the plain strobed port.
// How it works
// RULE1: Enable bit 0 gates event counter flag; resets to 0.
// RULE2: Accepting an interrupt never clears a flag; only software clears.
// RULE3: Writing 0 clears a flag; writing 1 does nothing.
// RULE4: Register one bit 7 set on timer A wrap from max to zero.
// RULE5: Register one bit 6 is plain read/write, reset 0.
// RULE6: Register one bit 5 always reads 1, writes ignored.
// RULE7: Register one bits 4..0 set by selected edge on external pins.
// RULE8: Register two bit 7 set on direct transfer by sleep.
// RULE9: Register two bit 6 set when conversion ends.
// RULE10: Register two bit 5 is plain read/write, reset 0.
// RULE11: Register two bit 4 set on capture edge or timer G overflow.
// RULE12: Register two bit 3 set on timer F high or full compare match.
// RULE13: Register two bit 2 set on timer F low compare match.
// RULE14: Both registers are 8 bits; flags reset to 0.
// RULE15: Register two bit 1 set on timer C overflow or underflow.
// RULE16: Register two bit 0 set on event counter overflow.
// RULE17: Request forwarded only when source occurs while enable is 1.
// RULE18: Set wins over a software clear in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "irf_regs.svh"

module irf_top
  import irf_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Peripheral events
  input  wire irf_events_t events,
  // Register port
  input  wire irf_bus_t    bus,
  output logic [7:0]       rdata,
  // Outputs to priority logic
  output logic [7:0]       req_one,
  output logic [7:0]       req_two,
  output logic             evcnt_irq_enable,
  output logic             irq
);

  // ==========================================================
  // State
  irf_state_t state;
  irf_state_t next_state;
  logic [7:0] set_one;
  logic [7:0] set_two;
  logic [7:0] clr_one;
  logic [7:0] clr_two;
  logic [`IRF_STAT_W-1:0] stat_set;
  logic       wr_one;
  logic       wr_two;

  // Set vectors from peripheral pulses
  always_comb begin
    set_one = `IRF_RST_ZERO;
    set_two = `IRF_RST_ZERO;
    set_one[`IRF_B1_TIMER_A] = events.timer_a_wrap;       // [RULE4]
    set_one[4:0]             = events.ext_edge;           // [RULE7]
    set_two[`IRF_B2_DIRECT]  = events.direct_xfer;        // [RULE8]
    set_two[`IRF_B2_ADC]     = events.adc_done;           // [RULE9]
    set_two[`IRF_B2_TIMER_G] = events.timer_g;            // [RULE11]
    set_two[`IRF_B2_TF_HIGH] = events.tf_high;            // [RULE12]
    set_two[`IRF_B2_TF_LOW]  = events.tf_low;             // [RULE13]
    set_two[`IRF_B2_TIMER_C] = events.timer_c;            // [RULE15]
    set_two[`IRF_B2_EVCNT]   = events.evcnt & state.evcnt_en; // [RULE1] [RULE16] [RULE17]
  end

  // Clear vectors: only bits written as 0 on flag positions
  assign wr_one  = bus.wr && (bus.addr == `IRF_OFS_FLAGS_ONE);
  assign wr_two  = bus.wr && (bus.addr == `IRF_OFS_FLAGS_TWO);
  assign clr_one = wr_one ? (~bus.wdata & `IRF_FLAG_MASK_ONE)
                          : `IRF_RST_ZERO;                // [RULE3]
  assign clr_two = wr_two ? (~bus.wdata & `IRF_FLAG_MASK_TWO)
                          : `IRF_RST_ZERO;                // [RULE3]
  // Summary events: any new flag in either register
  assign stat_set = {|set_two, |set_one};

  // Next state
  always_comb begin
    next_state = state;
    // Flags: set over clear, never cleared by acceptance
    next_state.flags_one = (state.flags_one & ~clr_one) | set_one; // [RULE18] [RULE2]
    next_state.flags_two = (state.flags_two & ~clr_two) | set_two; // [RULE18] [RULE2]
    // Plain reserved bits
    if (wr_one) begin
      next_state.flags_one[`IRF_B1_RSVD_RW] = bus.wdata[`IRF_B1_RSVD_RW]; // [RULE5]
    end
    if (wr_two) begin
      next_state.flags_two[`IRF_B2_RSVD_RW] = bus.wdata[`IRF_B2_RSVD_RW]; // [RULE10]
    end
    next_state.flags_one[`IRF_B1_RSVD_ONE] = 1'b1;        // [RULE6]
    // Enable, summary mask and status
    if (bus.wr && bus.addr == `IRF_OFS_ENABLE) begin
      next_state.evcnt_en = bus.wdata[`IRF_B_EVCNT_EN];   // [RULE1]
    end
    if (bus.wr && bus.addr == `IRF_OFS_IRQ_MASK) begin
      next_state.irq_mask = bus.wdata[`IRF_STAT_W-1:0];
    end
    if (bus.wr && bus.addr == `IRF_OFS_IRQ_STAT) begin
      next_state.irq_stat = (state.irq_stat & ~bus.wdata[`IRF_STAT_W-1:0])
                            | stat_set;
    end else begin
      next_state.irq_stat = state.irq_stat | stat_set;
    end
    // Read data, one cycle after the strobe; unmapped reads 0
    next_state.rdata = `IRF_RST_ZERO;
    if (bus.rd) begin
      case (bus.addr)
        `IRF_OFS_FLAGS_ONE: next_state.rdata = state.flags_one;
        `IRF_OFS_FLAGS_TWO: next_state.rdata = state.flags_two;
        `IRF_OFS_ENABLE:    next_state.rdata = {7'h00, state.evcnt_en};
        `IRF_OFS_IRQ_STAT:  next_state.rdata = {6'h00, state.irq_stat};
        `IRF_OFS_IRQ_MASK:  next_state.rdata = {6'h00, state.irq_mask};
        default:            next_state.rdata = `IRF_RST_ZERO;
      endcase
    end
    // Registered copies for outputs
    next_state.req_one = next_state.flags_one & `IRF_FLAG_MASK_ONE;
    next_state.req_two = next_state.flags_two & `IRF_FLAG_MASK_TWO;
    next_state.irq     = |(next_state.irq_stat & next_state.irq_mask);
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state           <= '0;
      state.flags_one <= `IRF_RST_ONE;                    // [RULE6] [RULE14]
      state.flags_two <= `IRF_RST_ZERO;                   // [RULE14]
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flip-flops
  assign rdata            = state.rdata;
  assign req_one          = state.req_one;
  assign req_two          = state.req_two;
  assign evcnt_irq_enable = state.evcnt_en;
  assign irq              = state.irq;

endmodule

`default_nettype wire

// *** testbench/irf_periph.sv ***
/* Peripheral side: turns fire requests into one-cycle event pulses.
   Assumes fire is driven just after the rising edge. */
`timescale 1ns/1ps
`default_nettype none
module irf_periph
  import irf_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Requests and pulses
  input  wire logic [12:0] fire,
  output irf_events_t      events
);
  // Quiet in reset, one pulse per request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) events <= '0;
    else events <= irf_events_t'(fire);
  end
endmodule
`default_nettype wire

// *** testbench/irf_monitor.sv ***
/* Port checker of irf_top.
   Assumes a bind onto irf_top. */
`timescale 1ns/1ps
`default_nettype none
module irf_monitor
  import irf_pkg::*;
(
  // Inputs of the block
  input wire logic        clk,
  input wire logic        rst_b,
  input wire irf_events_t events,
  input wire irf_bus_t    bus,
  // Outputs of the block
  input wire logic [7:0]  rdata,
  input wire logic [7:0]  req_one,
  input wire logic [7:0]  req_two,
  input wire logic        evcnt_irq_enable,
  input wire logic        irq
);
  // Set vectors in register layout
  wire logic [7:0] ev_one = {events.timer_a_wrap, 2'h0, events.ext_edge};
  wire logic [7:0] ev_two = {events.direct_xfer, events.adc_done, 1'h0,
    events.timer_g, events.tf_high, events.tf_low, events.timer_c,
    events.evcnt & evcnt_irq_enable};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_set_one;
    ev_one != 8'h00 |=> (req_one & $past(ev_one)) == $past(ev_one);
  endproperty
  a_set_one: assert property (p_set_one)
    else $error("event one not flagged");
  property p_set_two;
    ev_two != 8'h00 |=> (req_two & $past(ev_two)) == $past(ev_two);
  endproperty
  a_set_two: assert property (p_set_two)
    else $error("event two not flagged");
  property p_gate;
    events.evcnt && !evcnt_irq_enable && !req_two[0] |=> !req_two[0];
  endproperty
  a_gate: assert property (p_gate)
    else $error("gated event counter flagged");
  property p_keep;
    $fell(req_one[7]) |-> $past(bus.wr && bus.addr == 4'h0 && !bus.wdata[7]);
  endproperty
  a_keep: assert property (p_keep)
    else $error("flag one fell without clear");
  property p_keep_two;
    $fell(req_two[1]) |-> $past(bus.wr && bus.addr == 4'h1 && !bus.wdata[1]);
  endproperty
  a_keep_two: assert property (p_keep_two)
    else $error("flag two fell without clear");
  property p_no_set;
    $rose(req_two[4]) |-> $past(events.timer_g);
  endproperty
  a_no_set: assert property (p_no_set)
    else $error("flag rose without event");
  property p_win;
    events.adc_done && bus.wr && bus.addr == 4'h1 |=> req_two[6];
  endproperty
  a_win: assert property (p_win)
    else $error("clear beat set");
  property p_bit5;
    bus.rd && bus.addr == 4'h0 |=> rdata[5];
  endproperty
  a_bit5: assert property (p_bit5)
    else $error("bit five read low");
  property p_en;
    bus.wr && bus.addr == 4'h2 |=> evcnt_irq_enable == $past(bus.wdata[0]);
  endproperty
  a_en: assert property (p_en)
    else $error("enable not written");
endmodule
bind irf_top irf_monitor irf_monitor_i (.clk, .rst_b, .events, .bus, .rdata,
  .req_one, .req_two, .evcnt_irq_enable, .irq);
`default_nettype wire

// *** testbench/tb.sv ***
/* Self-checking bench of irf_top against a reference model.
   Assumes irf_periph as event source. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("Error %0t: got %h want %h", $time, g, e); end end
module tb;
  import irf_pkg::*;
  logic clk, rst_b, en, evcnt_irq_enable, irq;
  logic [12:0] fire;
  irf_events_t events;
  irf_bus_t bus;
  logic [7:0] rdata, req_one, req_two, m1, m2, x_rd;
  logic [1:0] st, mk;
  int err_count, compares;
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  irf_periph irf_periph_i (.clk, .rst_b, .fire, .events);
  irf_top irf_top_i (.clk, .rst_b, .events, .bus, .rdata, .req_one,
    .req_two, .evcnt_irq_enable, .irq);
  // Expected flags after one edge
  function automatic logic [7:0] n1(logic [7:0] m, logic w, logic [7:0] d,
      irf_events_t e);
    if (w) m = (m & d & 8'h9f) | {1'h0, d[6], 6'h00};
    return m | {e.timer_a_wrap, 2'h1, e.ext_edge};
  endfunction
  function automatic logic [7:0] n2(logic [7:0] m, logic w, logic [7:0] d,
      irf_events_t e, logic g);
    if (w) m = (m & d & 8'hdf) | {2'h0, d[5], 5'h00};
    return m | {e.direct_xfer, e.adc_done, 1'h0, e.timer_g, e.tf_high,
      e.tf_low, e.timer_c, e.evcnt & g};
  endfunction
  function automatic irf_bus_t bw(logic [3:0] a, logic [7:0] d, logic r);
    return '{a, d, !r, r};
  endfunction
  // Reference model of the register file
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {m1, m2, en, st, mk, x_rd} <= {8'h20, 8'h00, 1'h0, 4'h0, 8'h00};
    end else begin
      m1 <= n1(m1, bus.wr && bus.addr == 4'h0, bus.wdata, events);
      m2 <= n2(m2, bus.wr && bus.addr == 4'h1, bus.wdata, events, en);
      if (bus.wr && bus.addr == 4'h2) en <= bus.wdata[0];
      if (bus.wr && bus.addr == 4'h4) mk <= bus.wdata[1:0];
      st <= (st & ~((bus.wr && bus.addr == 4'h3) ? bus.wdata[1:0] : 2'h0))
        | {n2(8'h00, 1'h0, 8'h00, events, en) != 8'h00,
           n1(8'h00, 1'h0, 8'h00, events) != 8'h20};
      case (bus.rd ? bus.addr : 4'hf)
        4'h0: x_rd <= m1;
        4'h1: x_rd <= m2;
        4'h2: x_rd <= {7'h00, en};
        4'h3: x_rd <= {6'h00, st};
        4'h4: x_rd <= {6'h00, mk};
        default: x_rd <= 8'h00;
      endcase
    end
  end
  // One cycle of stimulus, then every output against the model
  task automatic step(input logic [12:0] f, input irf_bus_t b);
    @(posedge clk);
    fire <= f;
    bus <= b;
    @(negedge clk);
    `CHK(req_one, m1 & 8'h9f)
    `CHK(req_two, m2 & 8'hdf)
    `CHK(rdata, x_rd)
    `CHK(evcnt_irq_enable, en)
    `CHK(irq, |(st & mk))
  endtask
  task tally_and_finish;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Reset, corner cases, random traffic, second reset
  initial begin
    {rst_b, fire, bus, err_count, compares} = '0;
    void'($urandom(75639));
    for (int k = 0; k < 2; k++) begin
      // Idle bus and events so no strobe stands across reset
      step(13'h0000, '0);
      rst_b = 1'h0;
      repeat (5) @(negedge clk);
      rst_b = 1'h1;
      for (int a = 0; a < 6; a++) step(13'h0000, bw(4'(a), 8'h00, 1'h1));
      step(13'h1fff, bw(4'h4, 8'h03, 1'h0));
      step(13'h0000, bw(4'h1, 8'h00, 1'h0));
      step(13'h0000, bw(4'h0, 8'hff, 1'h0));
      step(13'h0000, bw(4'h0, 8'h00, 1'h1));
      repeat (3000) step(13'($urandom & $urandom & $urandom),
        ($urandom % 3 == 0) ? '0 : bw(4'($urandom % 6), 8'($urandom),
        1'($urandom)));
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
